/* design/xpd_decode.sv */
// extension-bus peripheral enable register and address window router
//
// Notes on behaviour
// - first can enable gates first can access
// - first can window external only both off
// - second can enable gates second can access
// - second can window external only both off
// - small ram enable picks internal or external
// - large ram enable picks internal or external
// - calendar window external only if cans off
// - both cans off: whole can range external
// - select register resets to 05h
// - select register frozen after global enable
// - emulation mode forces all five enables
// - calendar off: oscillator stops in power-down
// - calendar on: control bit decides oscillator
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module xpd_decode (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // cpu extension-bus access
  input  wire logic        cpu_req,
  input  wire logic        cpu_write,
  input  wire logic [23:0] cpu_addr,
  // routed access strobes
  output logic             can1_sel,
  output logic             can2_sel,
  output logic             small_ram_sel,
  output logic             large_ram_sel,
  output logic             rtc_sel,
  output logic             ext_req,
  output logic             access_dropped,
  output logic [23:0]      route_addr,
  output logic             route_write,
  // mode inputs and side controls
  input  wire logic        emu_mode,
  input  wire logic        powerdown,
  output logic             osc_enable,
  output logic             can1_pins_gpio,
  output logic             can2_pins_gpio
);


  // window table, indexed the same way as the select bits
  localparam int          NWIN = xpd_pkg::SEL_W;
  localparam logic [23:0] WIN_LO [NWIN] = '{
    xpd_pkg::CAN1_LO,
    xpd_pkg::CAN2_LO,
    xpd_pkg::SRAM_LO,
    xpd_pkg::LRAM_LO,
    xpd_pkg::RTC_LO
  };
  localparam logic [23:0] WIN_HI [NWIN] = '{
    xpd_pkg::CAN1_HI,
    xpd_pkg::CAN2_HI,
    xpd_pkg::SRAM_HI,
    xpd_pkg::LRAM_HI,
    xpd_pkg::RTC_HI
  };

  // register state and its next value
  xpd_pkg::xpd_state_t st_r;
  xpd_pkg::xpd_state_t st_nxt;

  // decode helpers
  logic [NWIN-1:0] win_hit;
  logic [NWIN-1:0] win_grant;
  logic [4:0]      eff_sel;
  logic            both_can_off;
  logic            gated_win;
  logic            ram_win;
  logic            int_hit;
  logic            route_ext;
  logic            route_drop;

  // apb helpers
  logic            apb_setup;
  logic            apb_access;
  logic            apb_wr;
  logic            sel_hit;
  logic            ctl_hit;
  logic            sts_hit;
  logic            reg_hit;
  logic [31:0]     rd_mux;

  // emulation overrides the programmed value, never rewrites it
  assign eff_sel = emu_mode ? xpd_pkg::SELECT_ALL : st_r.sel;

  // one comparator pair per window
  genvar gi;
  for (gi = 0; gi < NWIN; gi = gi + 1) begin : g_win
    assign win_hit[gi]   = (cpu_addr >= WIN_LO[gi]) &&
                           (cpu_addr <= WIN_HI[gi]);
    assign win_grant[gi] = win_hit[gi] & eff_sel[gi];
  end

  // calendar and can windows fall back outside only with both cans off;
  // otherwise the access is dropped so no stray external cycle appears
  assign both_can_off = ~eff_sel[xpd_pkg::CAN1_BIT] &
                        ~eff_sel[xpd_pkg::CAN2_BIT];
  assign gated_win    = win_hit[xpd_pkg::CAN1_BIT] |
                        win_hit[xpd_pkg::CAN2_BIT] |
                        win_hit[xpd_pkg::RTC_BIT];
  assign ram_win      = win_hit[xpd_pkg::SRAM_BIT] |
                        win_hit[xpd_pkg::LRAM_BIT];
  assign int_hit      = |win_grant;
  assign route_ext    = ~int_hit & (~gated_win | both_can_off);
  assign route_drop   = ~int_hit & gated_win & ~both_can_off;

  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable;
  assign apb_wr     = apb_access & pwrite;
  assign sel_hit    = (paddr == xpd_pkg::SELECT_OFF);
  assign ctl_hit    = (paddr == xpd_pkg::CONTROL_OFF);
  assign sts_hit    = (paddr == xpd_pkg::STATUS_OFF);
  assign reg_hit    = sel_hit | ctl_hit | sts_hit;

  // zero wait states: the answer comes in the first access cycle
  assign pready  = apb_access;
  assign pslverr = apb_access & ~reg_hit;

  // read mux; every unused bit stays zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_hit) begin
      rd_mux[xpd_pkg::SEL_W-1:0] = eff_sel;
    end else if (ctl_hit) begin
      rd_mux[xpd_pkg::GXE_BIT]    = st_r.gxe;
      rd_mux[xpd_pkg::OSCOFF_BIT] = st_r.oscoff;
    end else if (sts_hit) begin
      rd_mux[xpd_pkg::OSC_ST_BIT] = st_r.osc_run;
      rd_mux[xpd_pkg::EMU_ST_BIT] = emu_mode;
    end
  end

  always_comb begin
    st_nxt = st_r;
    // read data is latched in setup and stands through the access phase
    if (apb_setup) begin
      st_nxt.rdata = rd_mux;
    end
    // writes land at the edge where pready is sampled high
    if (apb_wr && sel_hit && !st_r.gxe) begin
      st_nxt.sel = pwdata[xpd_pkg::SEL_W-1:0];
    end
    if (apb_wr && ctl_hit) begin
      // global enable is sticky: only reset clears it
      st_nxt.gxe    = st_r.gxe | pwdata[xpd_pkg::GXE_BIT];
      st_nxt.oscoff = pwdata[xpd_pkg::OSCOFF_BIT];
    end
    // routed strobes stand for one cycle per accepted request
    st_nxt.can1_stb = cpu_req & win_grant[xpd_pkg::CAN1_BIT];
    st_nxt.can2_stb = cpu_req & win_grant[xpd_pkg::CAN2_BIT];
    st_nxt.sram_stb = cpu_req & win_grant[xpd_pkg::SRAM_BIT];
    st_nxt.lram_stb = cpu_req & win_grant[xpd_pkg::LRAM_BIT];
    st_nxt.rtc_stb  = cpu_req & win_grant[xpd_pkg::RTC_BIT];
    st_nxt.ext_stb  = cpu_req & route_ext;
    st_nxt.drop_stb = cpu_req & route_drop;
    if (cpu_req) begin
      st_nxt.addr = cpu_addr;
      st_nxt.wr   = cpu_write;
    end
    // oscillator may only keep running in power-down for an enabled clock
    st_nxt.osc_run   = ~powerdown |
                       (eff_sel[xpd_pkg::RTC_BIT] & ~st_r.oscoff);
    st_nxt.can1_gpio = ~eff_sel[xpd_pkg::CAN1_BIT];
    st_nxt.can2_gpio = ~eff_sel[xpd_pkg::CAN2_BIT];
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r <= xpd_pkg::STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output except pready and pslverr comes straight from the state register
  assign prdata         = st_r.rdata;
  assign can1_sel       = st_r.can1_stb;
  assign can2_sel       = st_r.can2_stb;
  assign small_ram_sel  = st_r.sram_stb;
  assign large_ram_sel  = st_r.lram_stb;
  assign rtc_sel        = st_r.rtc_stb;
  assign ext_req        = st_r.ext_stb;
  assign access_dropped = st_r.drop_stb;
  assign route_addr     = st_r.addr;
  assign route_write    = st_r.wr;
  assign osc_enable     = st_r.osc_run;
  assign can1_pins_gpio = st_r.can1_gpio;
  assign can2_pins_gpio = st_r.can2_gpio;

  first_can_on_a: assert property (
    @(posedge core_clk) disable iff (reset)
    cpu_req && win_grant[xpd_pkg::CAN1_BIT]
    |=> can1_sel)
    else $error("first can access not routed to its module");

  first_can_off_a: assert property (
    @(posedge core_clk) disable iff (reset)
    cpu_req && win_hit[xpd_pkg::CAN1_BIT] && !eff_sel[xpd_pkg::CAN1_BIT]
    |=> !can1_sel)
    else $error("disabled first can module was selected");

  first_can_pins_a: assert property (
    @(posedge core_clk) disable iff (reset)
    !eff_sel[xpd_pkg::CAN1_BIT]
    |=> can1_pins_gpio)
    else $error("first can pins not released");

  can1_window_ext_a: assert property (
    @(posedge core_clk) disable iff (reset)
    cpu_req && win_hit[xpd_pkg::CAN1_BIT] && both_can_off
    |=> ext_req)
    else $error("first can window not sent outside");

  second_can_on_a: assert property (
    @(posedge core_clk) disable iff (reset)
    cpu_req && win_grant[xpd_pkg::CAN2_BIT]
    |=> can2_sel)
    else $error("second can access not routed to its module");

  second_can_off_a: assert property (
    @(posedge core_clk) disable iff (reset)
    cpu_req && win_hit[xpd_pkg::CAN2_BIT] && !eff_sel[xpd_pkg::CAN2_BIT]
    |=> !can2_sel)
    else $error("disabled second can module was selected");

  second_can_pins_a: assert property (
    @(posedge core_clk) disable iff (reset)
    !eff_sel[xpd_pkg::CAN2_BIT]
    |=> can2_pins_gpio)
    else $error("second can pins not released");

  can2_window_ext_a: assert property (
    @(posedge core_clk) disable iff (reset)
    cpu_req && win_hit[xpd_pkg::CAN2_BIT] && both_can_off
    |=> ext_req)
    else $error("second can window not sent outside");

  can_window_drop_a: assert property (
    @(posedge core_clk) disable iff (reset)
    cpu_req && !int_hit && !both_can_off &&
    (win_hit[xpd_pkg::CAN1_BIT] || win_hit[xpd_pkg::CAN2_BIT])
    |=> access_dropped && !ext_req)
    else $error("can window went outside with a can module on");

  small_ram_route_a: assert property (
    @(posedge core_clk) disable iff (reset)
    cpu_req && win_hit[xpd_pkg::SRAM_BIT]
    |=> small_ram_sel == $past(eff_sel[xpd_pkg::SRAM_BIT]) &&
        ext_req == !$past(eff_sel[xpd_pkg::SRAM_BIT]))
    else $error("small ram window routed wrongly");

  large_ram_route_a: assert property (
    @(posedge core_clk) disable iff (reset)
    cpu_req && win_hit[xpd_pkg::LRAM_BIT]
    |=> large_ram_sel == $past(eff_sel[xpd_pkg::LRAM_BIT]) &&
        ext_req == !$past(eff_sel[xpd_pkg::LRAM_BIT]))
    else $error("large ram window routed wrongly");

  calendar_on_a: assert property (
    @(posedge core_clk) disable iff (reset)
    cpu_req && win_grant[xpd_pkg::RTC_BIT]
    |=> rtc_sel)
    else $error("calendar access not routed to the clock");

  calendar_off_a: assert property (
    @(posedge core_clk) disable iff (reset)
    cpu_req && win_hit[xpd_pkg::RTC_BIT] && !eff_sel[xpd_pkg::RTC_BIT]
    |=> ext_req == $past(both_can_off))
    else $error("disabled calendar window routed wrongly");

  route_addr_a: assert property (
    @(posedge core_clk) disable iff (reset)
    cpu_req
    |=> route_addr == $past(cpu_addr) && route_write == $past(cpu_write))
    else $error("routed address does not match the request");

  select_frozen_a: assert property (
    @(posedge core_clk) disable iff (reset)
    st_r.gxe
    |=> $stable(st_r.sel))
    else $error("select register changed after global enable");

  select_write_a: assert property (
    @(posedge core_clk) disable iff (reset)
    apb_wr && sel_hit && !st_r.gxe
    |=> st_r.sel == $past(pwdata[xpd_pkg::SEL_W-1:0]))
    else $error("select write did not land");

  emu_route_a: assert property (
    @(posedge core_clk) disable iff (reset)
    emu_mode && cpu_req && ram_win
    |=> small_ram_sel || large_ram_sel)
    else $error("emulation did not enable the ram windows");

  emu_readback_a: assert property (
    @(posedge core_clk) disable iff (reset)
    emu_mode && apb_setup && sel_hit
    |=> prdata[xpd_pkg::SEL_W-1:0] == xpd_pkg::SELECT_ALL)
    else $error("emulation select value not all ones");

  osc_stop_a: assert property (
    @(posedge core_clk) disable iff (reset)
    powerdown && !eff_sel[xpd_pkg::RTC_BIT]
    |=> !osc_enable)
    else $error("oscillator kept running with calendar off");

  osc_choice_a: assert property (
    @(posedge core_clk) disable iff (reset)
    powerdown && eff_sel[xpd_pkg::RTC_BIT]
    |=> osc_enable == !$past(st_r.oscoff))
    else $error("oscillator ignored its power-down choice");

  no_ext_internal_a: assert property (
    @(posedge core_clk) disable iff (reset)
    cpu_req && int_hit
    |=> !ext_req)
    else $error("enabled internal window went outside");

  one_route_a: assert property (
    @(posedge core_clk) disable iff (reset)
    $onehot0({can1_sel, can2_sel, small_ram_sel, large_ram_sel,
              rtc_sel, ext_req, access_dropped}))
    else $error("more than one route for one access");

  upper_zero_a: assert property (
    @(posedge core_clk) disable iff (reset)
    apb_setup && sel_hit
    |=> prdata[31:xpd_pkg::SEL_W] == '0)
    else $error("upper select bits read nonzero");

endmodule // xpd_decode

/* design/xpd_pkg.sv */
// constants and state type of the extension-bus peripheral select decoder
package xpd_pkg;

  // register byte addresses on the apb bus
  localparam logic [15:0] SELECT_OFF  = 16'hF024;
  localparam logic [15:0] CONTROL_OFF = 16'hF028;
  localparam logic [15:0] STATUS_OFF  = 16'hF02C;

  // field positions of xbus_peripheral_select
  localparam int          CAN1_BIT    = 0;
  localparam int          CAN2_BIT    = 1;
  localparam int          SRAM_BIT    = 2;
  localparam int          LRAM_BIT    = 3;
  localparam int          RTC_BIT     = 4;
  localparam int          SEL_W       = 5;

  // field positions of the control register
  localparam int          GXE_BIT     = 0;
  localparam int          OSCOFF_BIT  = 1;

  // field positions of the status register
  localparam int          OSC_ST_BIT  = 5;
  localparam int          EMU_ST_BIT  = 6;

  // select reset value and emulation value
  localparam logic [4:0]  SELECT_RST  = 5'h05;
  localparam logic [4:0]  SELECT_ALL  = 5'h1F;

  // address windows (24-bit extension-bus addresses)
  localparam logic [23:0] CAN1_LO     = 24'h00EF00;
  localparam logic [23:0] CAN1_HI     = 24'h00EFFF;
  localparam logic [23:0] CAN2_LO     = 24'h00EE00;
  localparam logic [23:0] CAN2_HI     = 24'h00EEFF;
  localparam logic [23:0] RTC_LO      = 24'h00EC00;
  localparam logic [23:0] RTC_HI      = 24'h00ECFF;
  localparam logic [23:0] SRAM_LO     = 24'h00E000;
  localparam logic [23:0] SRAM_HI     = 24'h00E7FF;
  localparam logic [23:0] LRAM_LO     = 24'h00C000;
  localparam logic [23:0] LRAM_HI     = 24'h00DFFF;

  typedef struct packed {
    logic [4:0]  sel;
    logic        gxe;
    logic        oscoff;
    logic [31:0] rdata;
    logic        can1_stb;
    logic        can2_stb;
    logic        sram_stb;
    logic        lram_stb;
    logic        rtc_stb;
    logic        ext_stb;
    logic        drop_stb;
    logic [23:0] addr;
    logic        wr;
    logic        osc_run;
    logic        can1_gpio;
    logic        can2_gpio;
  } xpd_state_t;

  // state after reset: oscillator running, pins follow the reset enables
  localparam xpd_state_t  STATE_RST   = '{
    sel:       SELECT_RST,
    osc_run:   1'b1,
    can1_gpio: ~SELECT_RST[CAN1_BIT],
    can2_gpio: ~SELECT_RST[CAN2_BIT],
    default:   '0
  };

endpackage

/* testbench/xpd_ext_mem.sv */
// external memory stand-in: counts accesses routed off chip
`timescale 1ns/1ps
module xpd_ext_mem (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       ext_req,
  output logic      [3:0] hits
);
  logic prev_r;
  // count starts only, so a held strobe is one access
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hits   <= 4'h0;
      prev_r <= 1'b0;
    end else begin
      prev_r <= ext_req;
      if (ext_req && !prev_r) hits <= hits + 4'h1;
    end
  end
endmodule // xpd_ext_mem

/* testbench/tb_top.sv */
// bench for the peripheral select decoder
`timescale 1ns/1ps
`define CHK(a,e) begin checked++; if ((a)!==(e)) begin error_cnt++; \
  $display("ERROR %0t %h %h",$time,a,e); end end
module tb_top;
  logic c=0,rs=1,ps=0,pe=0,pw=0,rq=0,cw=0,em=0,pd=0;
  logic pr,se,sr,s1,s2,r1,r2,rt,ex,dr,rw,oe,g1,g2;
  logic [15:0] pa=0;
  logic [31:0] wd=0,prd,rd;
  logic [23:0] ca=0,ra;
  logic [3:0]  hits;
  int error_cnt=0,checked=0,n;
  always #5 c=~c;
  xpd_decode u_dut(.core_clk(c),.reset(rs),.psel(ps),.penable(pe),
    .pwrite(pw),.paddr(pa),.pwdata(wd),.prdata(prd),.pready(pr),
    .pslverr(sr),.cpu_req(rq),.cpu_write(cw),.cpu_addr(ca),.can1_sel(s1),
    .can2_sel(s2),.small_ram_sel(r1),.large_ram_sel(r2),.rtc_sel(rt),
    .ext_req(ex),.access_dropped(dr),.route_addr(ra),.route_write(rw),
    .emu_mode(em),.powerdown(pd),.osc_enable(oe),.can1_pins_gpio(g1),
    .can2_pins_gpio(g2));
  xpd_ext_mem u_mem(.core_clk(c),.reset(rs),.ext_req(ex),.hits(hits));
  task wrap_up;
    if (error_cnt==0 && checked>0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task apb(input logic w,input logic [15:0] a,input logic [31:0] d);
    ps<=1; pw<=w; pa<=a; wd<=d; @(posedge c); pe<=1; n=0;
    do begin @(posedge c); n++; end while (pr!==1'b1 && n<20);
    rd=prd; se=sr; ps<=0; pe<=0;
    if (n>=20) begin error_cnt++; wrap_up; end
    @(posedge c);
  endtask
  task acc(input logic [23:0] a,input logic [6:0] e);
    ca<=a; cw<=a[8]; rq<=1; @(posedge c); rq<=0; #1;
    `CHK({dr,ex,rt,r2,r1,s2,s1},e)
    `CHK({ra,rw},{a,a[8]})
    @(posedge c);
  endtask
  initial begin
    repeat (4) @(posedge c);
    rs<=0; @(posedge c);
    apb(0,xpd_pkg::SELECT_OFF,0); `CHK(rd,32'h5)
    `CHK({g2,g1},2'h2)
    acc(24'h00EF00,7'h01);
    acc(24'h00E000,7'h04);
    acc(24'h00EE00,7'h40);
    acc(24'h00EC00,7'h40);
    pd<=1; @(posedge c); #1;
    `CHK(oe,1'b0)
    pd<=0; em<=1; @(posedge c);
    acc(24'h00C000,7'h08);
    em<=0;
    apb(1,xpd_pkg::SELECT_OFF,32'hFFFFFFE0);
    apb(0,xpd_pkg::SELECT_OFF,0); `CHK(rd,32'h0)
    acc(24'h00EF00,7'h20);
    acc(24'h00EE00,7'h20);
    acc(24'h00EC00,7'h20);
    acc(24'h00C000,7'h20);
    acc(24'h00E000,7'h20);
    apb(1,xpd_pkg::SELECT_OFF,32'h2);
    acc(24'h00EF00,7'h40);
    apb(1,xpd_pkg::SELECT_OFF,32'h1F);
    acc(24'h00C000,7'h08);
    acc(24'h00EE00,7'h02);
    acc(24'h00EC00,7'h10);
    pd<=1; @(posedge c); #1;
    `CHK(oe,1'b1)
    apb(1,xpd_pkg::CONTROL_OFF,32'h3);
    #1;
    `CHK(oe,1'b0)
    pd<=0;
    apb(1,xpd_pkg::SELECT_OFF,32'h0);
    apb(0,xpd_pkg::SELECT_OFF,0); `CHK(rd,32'h1F)
    apb(0,16'h0000,0); `CHK(se,1'b1)
    `CHK(hits,4'h5)
    wrap_up;
  end
endmodule // tb_top
